/* rsc_consts.svh */
// rsc_consts.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by the reset/cause block, its package and its bench
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_ADDR_W 4
`define RSC_OFF_POWER_CONTROL_REG 4'h0
`define RSC_OFF_STAT 4'h4
`define RSC_OFF_CTRL 4'h8
`define RSC_OFF_PC 4'hC
`define RSC_BIT_OVF 7
`define RSC_BIT_UNF 6
`define RSC_BIT_EXT 3
`define RSC_BIT_RI 2
`define RSC_BIT_POR 1
`define RSC_BIT_BOR 0
`define RSC_BIT_TO 4
`define RSC_BIT_PD 3
`define RSC_CTRL_PULLUP 0
`define RSC_PC_ZERO 16'h0000
`define RSC_PC_VECTOR 16'h0004
`define RSC_POWER_CONTROL_REG_POR 8'h0C
`define RSC_PUT_MS 64
`define RSC_CLK_HZ 50000000
`define RSC_PUT_CYC ((`RSC_PUT_MS * `RSC_CLK_HZ) / 1000)
`define RSC_FILT_CYC 4
`define RSC_OK 2'b00
`define RSC_SLVERR 2'b10
`endif

/* rsc_pin_model.sv */
// rsc_pin_model.sv: the reset pin as seen from outside, with a driver and weak pull-up
// assumes the bench moves drv_en just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_model (
  input wire logic ref_clk,
  input wire logic drv_en,
  input wire logic pull_en,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin
);
  logic float_val = 1'b0;
  // an unpulled, undriven pin flips every cycle so no stale level can pass for a real one
  always @(posedge ref_clk) begin
    float_val <= ~float_val;
  end
  // external driver only pulls low; idle pin is held high by the weak pull-up
  assign pin = drv_en ? 1'b0 : dev_oe ? dev_out : pull_en ? 1'b1 : float_val;
endmodule : rsc_pin_model
`default_nettype wire

/* rsc_pkg.sv */
// rsc_pkg.sv: types shared by the reset and cause logic
// assumes rsc_consts.svh alongside
`include "rsc_consts.svh"
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_ST_HOLD = 2'b00,
    RSC_ST_WAIT = 2'b01,
    RSC_ST_RUN = 2'b10
  } rsc_state_type;
  // cause events from core, one-cycle pulses
  typedef struct packed {
    logic wdt_timeout;
    logic wdt_wake;
    logic irq_wake;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic prog_exit;
    logic brownout;
  } rsc_event_type;
  typedef struct packed {
    logic ext_reset_enable;
    logic low_voltage_prog;
    logic stack_reset_enable;
    logic powerup_timer_enable_n;
    logic osc_start_needed;
  } rsc_cfg_type;
endpackage : rsc_pkg

/* rsc_reset_cause.sv */
// rsc_reset_cause.sv: reset source merging, start-up sequencing, cause flags
// assumes one 50 MHz clock, config straps stable, AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
`include "rsc_consts.svh"
// Overview of operation
// - pin reset off only when pin enable and low-voltage-prog are both zero.
// - enabled pin held low keeps the device in reset.
// - short glitches on the reset pin are filtered out.
// - internal resets never drive the pin low; only a weak pull-up.
// - disabled pin is a plain input with software pull-up.
// - missed watchdog clear resets and marks timeout flags.
// - reset instruction resets and clears its flag, others kept.
// - stack faults reset only when enabled; set matching flag.
// - leaving programming mode acts exactly as power-on.
// - power-up timer delays only power-on, brown-out or programming exit, when enabled.
// - start needs timer done, oscillator count done, pin released.
// - timers run regardless of pin; start right after pin rises.
// - power-on and brown-out set flags per their fixed patterns.
// - pin reset in run clears its flag only, pc to zero.
// - pin reset in sleep also sets timeout, clears power-down.
// - watchdog reset to zero; watchdog wake continues at pc plus one.
// - irq wake continues at pc plus one; vectors if irqs enabled.
// - stack resets reload zero, leave other flags unchanged.
// - unimplemented flag bits read as zero.
// - power-up timer: the 64 ms count overflows 32 bits and loads 4293872329 cycles; active when its enable is cleared.
// - flags at bits 7,6,3..0; firmware writes zero to clear.
module rsc_reset_cause import rsc_pkg::*; #(
  parameter int PUT_CYCLES = `RSC_PUT_CYC,
  parameter int FILT_CYCLES = `RSC_FILT_CYC,
  parameter int OST_CYCLES = 1024
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ext_reset_pin_in,
  output logic ext_reset_pin_out,
  output logic ext_reset_pin_oe,
  output logic ext_reset_pin_pullup,
  output logic gpio_in,
  input wire rsc_cfg_type cfg,
  input wire rsc_event_type evt,
  input wire logic in_sleep,
  input wire logic global_irq_enable,
  input wire logic [15:0] pc_now,
  output logic core_reset,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic irq_vector,
  input wire logic [`RSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic pin_meta, pin_sync;
  logic [7:0] filt_cnt;
  logic pin_low;
  logic pin_en;
  logic [31:0] put_cnt;
  logic [15:0] ost_cnt;
  rsc_state_type state;
  logic [7:0] power_control_reg;
  logic to_n, pd_n;
  logic pullup_sw;
  logic startup_done;
  logic [`RSC_ADDR_W-1:0] aw_addr;
  logic aw_have, w_have;
  logic [31:0] w_data;
  logic power_control_reg_wr;
  logic pwr_event;
  logic pin_fall;
  logic pin_low_d;
  logic w_strb0;
  logic next_aw_have, next_w_have, next_bvalid;

  // pin function enable: lvp forces it on
  assign pin_en = cfg.ext_reset_enable | cfg.low_voltage_prog;
  assign pwr_event = evt.prog_exit | evt.brownout;
  assign pin_fall = pin_low & ~pin_low_d;
  assign power_control_reg_wr = aw_have & w_have & ~s_axi_bvalid & (aw_addr == `RSC_OFF_POWER_CONTROL_REG);
  // write handshake state after this edge, so the ready outputs can come from flops
  assign next_bvalid = (aw_have & w_have & ~s_axi_bvalid) | (s_axi_bvalid & ~s_axi_bready);
  assign next_aw_have = ~(aw_have & w_have & ~s_axi_bvalid) & (aw_have | (s_axi_awvalid & s_axi_awready));
  assign next_w_have = ~(aw_have & w_have & ~s_axi_bvalid) & (w_have | (s_axi_wvalid & s_axi_wready));

  // two-flop synchroniser; first flop read only by the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= ext_reset_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // glitch filter: reset only after FILT_CYCLES consecutive lows
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filt_cnt <= 8'h00;
      pin_low <= 1'b0;
      pin_low_d <= 1'b0;
    end else begin
      pin_low_d <= pin_low;
      if (pin_sync || !pin_en) begin
        filt_cnt <= 8'h00;
        pin_low <= 1'b0;
      end else if (filt_cnt >= 8'(FILT_CYCLES - 1)) begin
        pin_low <= 1'b1;
      end else begin
        filt_cnt <= filt_cnt + 8'h01;
      end
    end
  end

  // pin never driven; pull-up fixed when enabled, software otherwise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe <= 1'b0;
      ext_reset_pin_pullup <= 1'b1;
      gpio_in <= 1'b1;
    end else begin
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe <= 1'b0;
      ext_reset_pin_pullup <= pin_en ? 1'b1 : pullup_sw;
      gpio_in <= pin_en ? 1'b1 : pin_sync;
    end
  end

  // start-up timers run independent of the pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      put_cnt <= 32'h0;
      ost_cnt <= 16'h0;
    end else if (pwr_event || state == RSC_ST_HOLD) begin // hold also follows power-on
      put_cnt <= cfg.powerup_timer_enable_n ? 32'h0 : 32'(PUT_CYCLES);
      ost_cnt <= cfg.osc_start_needed ? 16'(OST_CYCLES) : 16'h0;
    end else begin
      if (put_cnt != 32'h0) put_cnt <= put_cnt - 32'h1;
      if (ost_cnt != 16'h0) ost_cnt <= ost_cnt - 16'h1;
    end
  end
  assign startup_done = (put_cnt == 32'h0) && (ost_cnt == 16'h0);

  // sequencer: hold, wait for timers and pin, run
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= RSC_ST_HOLD;
      core_reset <= 1'b1;
    end else begin
      unique case (state)
        RSC_ST_HOLD: begin
          state <= RSC_ST_WAIT;
          core_reset <= 1'b1;
        end
        RSC_ST_WAIT: begin
          core_reset <= 1'b1;
          if (pwr_event) state <= RSC_ST_HOLD;
          else if (startup_done && !pin_low) state <= RSC_ST_RUN;
        end
        RSC_ST_RUN: begin
          core_reset <= 1'b0;
          if (pwr_event || pin_low || evt.wdt_timeout || evt.reset_instr ||
              (cfg.stack_reset_enable && (evt.stack_over || evt.stack_under))) begin
            state <= RSC_ST_WAIT;
            core_reset <= 1'b1;
          end
        end
        default: begin
          state <= RSC_ST_HOLD;
          core_reset <= 1'b1;
        end
      endcase
    end
  end

  // program counter load choice
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_load <= 1'b0;
      pc_value <= `RSC_PC_ZERO;
      irq_vector <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      irq_vector <= 1'b0;
      if (state == RSC_ST_WAIT && startup_done && !pin_low && !pwr_event) begin
        pc_load <= 1'b1;
        pc_value <= `RSC_PC_ZERO;
      end else if (state == RSC_ST_RUN && (evt.wdt_wake || evt.irq_wake)) begin
        pc_load <= 1'b1;
        pc_value <= pc_now + 16'h0001;
        irq_vector <= evt.irq_wake & global_irq_enable;
      end
    end
  end

  // cause flags; hardware events win over firmware clears
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      power_control_reg <= `RSC_POWER_CONTROL_REG_POR; // power-on clears its own flag; brown-out bit chosen 0
      to_n <= 1'b1;
      pd_n <= 1'b1;
    end else begin
      if (power_control_reg_wr && w_strb0) begin
        // firmware may only clear; writing one leaves a bit as is
        power_control_reg[`RSC_BIT_OVF] <= power_control_reg[`RSC_BIT_OVF] & w_data[`RSC_BIT_OVF];
        power_control_reg[`RSC_BIT_UNF] <= power_control_reg[`RSC_BIT_UNF] & w_data[`RSC_BIT_UNF];
        power_control_reg[3:0] <= power_control_reg[3:0] & w_data[3:0];
      end
      if (evt.prog_exit) begin
        power_control_reg <= `RSC_POWER_CONTROL_REG_POR;
        to_n <= 1'b1;
        pd_n <= 1'b1;
      end else if (evt.brownout) begin
        power_control_reg[`RSC_BIT_OVF] <= 1'b0;
        power_control_reg[`RSC_BIT_UNF] <= 1'b0;
        power_control_reg[`RSC_BIT_EXT] <= 1'b1;
        power_control_reg[`RSC_BIT_RI] <= 1'b1;
        power_control_reg[`RSC_BIT_BOR] <= 1'b0;
        to_n <= 1'b1;
        pd_n <= 1'b1;
      end else if (state == RSC_ST_RUN) begin
        if (pin_fall) begin
          power_control_reg[`RSC_BIT_EXT] <= 1'b0;
          if (in_sleep) begin
            to_n <= 1'b1;
            pd_n <= 1'b0;
          end
        end
        if (evt.wdt_timeout) to_n <= 1'b0;
        if (evt.wdt_wake) begin
          to_n <= 1'b0;
          pd_n <= 1'b0;
        end
        if (evt.irq_wake) begin
          to_n <= 1'b1;
          pd_n <= 1'b0;
        end
        if (evt.reset_instr) power_control_reg[`RSC_BIT_RI] <= 1'b0;
        if (cfg.stack_reset_enable && evt.stack_over) power_control_reg[`RSC_BIT_OVF] <= 1'b1;
        if (cfg.stack_reset_enable && evt.stack_under) power_control_reg[`RSC_BIT_UNF] <= 1'b1;
      end
    end
  end

  // write channel: address and data taken in either order, one at a time
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSC_OK;
      pullup_sw <= 1'b1;
      w_strb0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= ~next_aw_have & ~next_bvalid;
      s_axi_wready <= ~next_w_have & ~next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0]; // strobe kept, the master may move it once taken
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        if (aw_addr == `RSC_OFF_POWER_CONTROL_REG || aw_addr == `RSC_OFF_STAT || aw_addr == `RSC_OFF_PC)
          s_axi_bresp <= `RSC_OK;
        else if (aw_addr == `RSC_OFF_CTRL) begin
          s_axi_bresp <= `RSC_OK;
          if (w_strb0) pullup_sw <= w_data[`RSC_CTRL_PULLUP];
        end else s_axi_bresp <= `RSC_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel; unimplemented bits read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RSC_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RSC_OK;
      unique case (s_axi_araddr)
        `RSC_OFF_POWER_CONTROL_REG: s_axi_rdata <= {24'h0, power_control_reg & 8'hCF};
        `RSC_OFF_STAT: s_axi_rdata <= {27'h0, to_n, pd_n, 3'b000};
        `RSC_OFF_CTRL: s_axi_rdata <= {29'h0, state == RSC_ST_RUN, pin_low, pullup_sw};
        `RSC_OFF_PC: s_axi_rdata <= {16'h0, pc_value};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RSC_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // read-address ready from a flop: low while a read answer stands
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) s_axi_arready <= 1'b1;
    else s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !(s_axi_rvalid && !s_axi_rready);
  end

  sequence s_pin_held;
    pin_low ##1 pin_low;
  endsequence
  chk_pin_never_driven: assert property (@(posedge ref_clk) disable iff (!nrst)
    !ext_reset_pin_oe) else $error("reset pin driven");
  chk_pin_holds_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_pin_held |-> core_reset) else $error("core ran with pin low");
  chk_pin_disabled_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(cfg.ext_reset_enable | cfg.low_voltage_prog) |=> !pin_low)
    else $error("pin reset while disabled");
  chk_glitch_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(pin_low) |-> $past(!pin_sync, 1) && $past(!pin_sync, FILT_CYCLES))
    else $error("glitch caused reset");
  chk_ri_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == RSC_ST_RUN && evt.reset_instr && !pwr_event) |=> !power_control_reg[`RSC_BIT_RI])
    else $error("ri flag not cleared");
  chk_stack_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == RSC_ST_RUN && evt.stack_over && !cfg.stack_reset_enable && !pwr_event
     && !pin_low && !evt.wdt_timeout && !evt.reset_instr && !evt.stack_under)
    |=> state == RSC_ST_RUN) else $error("stack reset while disabled");
  chk_wdt_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == RSC_ST_RUN && evt.wdt_timeout && !pwr_event && !evt.irq_wake)
    |=> !to_n && core_reset) else $error("watchdog reset flags wrong");
  chk_start_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == RSC_ST_WAIT && !startup_done) |=> state != RSC_ST_RUN)
    else $error("ran before timers done");
  chk_wake_pc: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == RSC_ST_RUN && evt.irq_wake && !(state == RSC_ST_WAIT))
    |=> pc_load && pc_value == $past(pc_now) + 16'h0001) else $error("wake pc wrong");
endmodule : rsc_reset_cause
`default_nettype wire

/* rsc_reset_cause_tb_top.sv */
// rsc_reset_cause_tb_top.sv: self-checking bench with a flag model for the reset block
// assumes rsc_pkg, rsc_consts.svh and rsc_pin_model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "rsc_consts.svh"
module rsc_reset_cause_tb_top import rsc_pkg::*; ;
  localparam int PUT = 20;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic drv_en, in_sleep, global_irq_enable, core_reset, pc_load, irq_vector, gpio_in;
  logic ext_reset_pin_in, ext_reset_pin_out, ext_reset_pin_oe, ext_reset_pin_pullup;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] pc_now, pc_value;
  rsc_cfg_type cfg;
  rsc_event_type evt;
  int failures = 0;
  int checked = 0;
  int exp_power_control_reg, exp_stat;
  logic [15:0] pc_q[$];
  rsc_pin_model i_rsc_pin_model (.ref_clk, .drv_en, .pull_en(ext_reset_pin_pullup),
    .dev_oe(ext_reset_pin_oe), .dev_out(ext_reset_pin_out), .pin(ext_reset_pin_in));
  rsc_reset_cause #(.PUT_CYCLES(PUT), .FILT_CYCLES(4), .OST_CYCLES(8)) i_rsc_reset_cause (
    .ref_clk, .nrst, .ext_reset_pin_in, .ext_reset_pin_out, .ext_reset_pin_oe,
    .ext_reset_pin_pullup, .gpio_in, .cfg, .evt, .in_sleep, .global_irq_enable, .pc_now,
    .core_reset, .pc_load, .pc_value, .irq_vector, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  task automatic end_sim;
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp_bit
  // write: address and data offered together, bready held until the response
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp_reg({30'h0, s_axi_bresp}, {30'h0, `RSC_OK}, "write response");
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    cmp_reg(d & m, e, "register read");
  endtask : chk_reg
  // brown-out bit is masked in the cause register and checked on its own after brown-out
  task automatic chk_flags;
    chk_reg(`RSC_OFF_POWER_CONTROL_REG, 32'hFE, exp_power_control_reg & 32'hFE);
    chk_reg(`RSC_OFF_STAT, 32'hFF, exp_stat);
  endtask : chk_flags
  task automatic wait_rst(input logic v, input int max);
    int n;
    n = 0;
    while (core_reset !== v && n < max) begin
      @(posedge ref_clk);
      n++;
    end
    cmp_bit(core_reset, v, "core reset level");
  endtask : wait_rst
  task automatic hold_chk(input logic v, input int cyc);
    repeat (cyc) begin
      @(posedge ref_clk);
      cmp_bit(core_reset, v, "core reset held");
    end
  endtask : hold_chk
  task automatic fire(input logic [7:0] e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= 8'h00;
  endtask : fire
  task automatic rst_evt(input logic [7:0] e);
    fire(e);
    wait_rst(1'b1, 10);
    wait_rst(1'b0, 40);
  endtask : rst_evt
  // counts how long the core stays in reset; the bound keeps a stuck reset from hanging
  task automatic rst_len(output int n);
    n = 0;
    wait_rst(1'b1, 10);
    while (core_reset !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    cmp_bit(core_reset, 1'b0, "reset released");
  endtask : rst_len
  task automatic pin_rst;
    drv_en <= 1'b1;
    wait_rst(1'b1, 12);
    hold_chk(1'b1, 30);
    drv_en <= 1'b0;
    wait_rst(1'b0, 10);
    exp_power_control_reg = exp_power_control_reg & 32'hF7;
  endtask : pin_rst
  // the pin must never be driven by the device
  always @(posedge ref_clk) begin
    if (nrst) cmp_bit(ext_reset_pin_oe | ext_reset_pin_out, 1'b0, "pin driven");
  end
  // whole run is well under 1000 cycles, so over twenty times that means a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] pcv;
    int n;
    void'($urandom(40));
    {drv_en, in_sleep, global_irq_enable, s_axi_awvalid, s_axi_wvalid} = 5'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hF, 32'h0};
    pc_now = 16'h0000;
    evt = 8'h00;
    cfg = 5'h12;
    exp_power_control_reg = 32'h0C;
    exp_stat = 32'h18;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_rst(1'b0, 40); // start once timers and pin allow
    chk_flags; // power-on pattern, unused bits zero
    axi_rd(4'h2, d, r);
    cmp_reg({30'h0, r}, {30'h0, `RSC_SLVERR}, "unmapped response");
    cmp_reg(d, 32'h0, "unmapped data");
    drv_en <= 1'b1;
    repeat (1 + $urandom % 2) @(posedge ref_clk);
    drv_en <= 1'b0;
    hold_chk(1'b0, 12); // short low pulse is ignored
    pin_rst; // pin held low keeps reset, release starts at once
    chk_flags; // only the pin flag cleared
    chk_reg(`RSC_OFF_PC, 32'hFFFF, 32'h0); // restart address zero
    rst_evt(8'h10);
    exp_power_control_reg = exp_power_control_reg & 32'hFB;
    chk_flags; // instruction flag cleared, rest kept
    fire(8'h08);
    hold_chk(1'b0, 8); // stack fault ignored while disabled
    cfg.stack_reset_enable <= 1'b1;
    rst_evt(8'h08);
    exp_power_control_reg = exp_power_control_reg | 32'h80;
    chk_flags; // overflow flag set, status kept
    rst_evt(8'h04);
    exp_power_control_reg = exp_power_control_reg | 32'h40;
    chk_flags; // underflow flag set, status kept
    rst_evt(8'h80);
    exp_stat = 32'h08;
    chk_flags; // watchdog reset clears the timeout flag
    chk_reg(`RSC_OFF_PC, 32'hFFFF, 32'h0); // watchdog restarts at zero
    axi_wr(`RSC_OFF_POWER_CONTROL_REG, 32'h00); // firmware clears every cause flag
    axi_wr(`RSC_OFF_POWER_CONTROL_REG, 32'hFF); // writing ones sets nothing
    exp_power_control_reg = 32'h00;
    chk_flags; // cleared flags stay cleared
    cfg.powerup_timer_enable_n <= 1'b0;
    cfg.osc_start_needed <= 1'b1;
    fire(8'h01);
    rst_len(n);
    cmp_bit(n >= PUT, 1'b1, "power-up delay"); // timer active when enable cleared
    exp_power_control_reg = 32'h0C;
    exp_stat = 32'h18;
    chk_flags; // brown-out pattern
    chk_reg(`RSC_OFF_POWER_CONTROL_REG, 32'h01, 32'h0); // brown-out flag cleared
    cfg <= 5'h16;
    fire(8'h01);
    rst_len(n);
    cmp_bit(n < PUT, 1'b1, "no power-up delay"); // timer off when its enable is set
    cfg.powerup_timer_enable_n <= 1'b0;
    drv_en <= 1'b1;
    fire(8'h01);
    repeat (PUT + 20) @(posedge ref_clk);
    drv_en <= 1'b0;
    wait_rst(1'b0, 8); // timers ran while pin low
    axi_wr(`RSC_OFF_POWER_CONTROL_REG, 32'h00);
    fire(8'h02);
    rst_len(n);
    cmp_bit(n >= PUT, 1'b1, "exit delay"); // programming exit acts as power-on
    chk_flags; // power-on pattern again
    cfg.powerup_timer_enable_n <= 1'b1;
    in_sleep <= 1'b1;
    // three wake-ups: watchdog, interrupt enabled, interrupt masked
    for (int i = 0; i < 3; i++) begin
      pcv = 16'($urandom);
      pc_now <= pcv;
      global_irq_enable <= (i == 1);
      pc_q.push_back(pcv + 16'h1);
      fire(i == 0 ? 8'h40 : 8'h20);
      n = 0;
      while (pc_load !== 1'b1 && n < 10) begin
        @(posedge ref_clk);
        n++;
      end
      cmp_bit(pc_load, 1'b1, "wake load");
      cmp_reg({16'h0, pc_value}, {16'h0, pc_q.pop_front()}, "wake pc");
      cmp_bit(irq_vector, i == 1, "vector");
      cmp_bit(core_reset, 1'b0, "wake without reset");
      exp_stat = (i == 0) ? 32'h00 : 32'h10;
      chk_flags; // wake flags
    end
    fire(8'h40); // timeout flag cleared first, so the sleep pin reset must set it
    pin_rst;
    exp_stat = 32'h10;
    chk_flags; // pin reset in sleep sets timeout, clears power-down
    in_sleep <= 1'b0;
    // pin enable table: disabled, enabled by its own bit, enabled by low-voltage programming
    for (int i = 0; i < 3; i++) begin
      cfg.ext_reset_enable <= (i == 1);
      cfg.low_voltage_prog <= (i == 2);
      axi_wr(`RSC_OFF_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      cmp_bit(ext_reset_pin_pullup, 1'b1, "pull-up on");
      axi_wr(`RSC_OFF_CTRL, 32'h0);
      repeat (3) @(posedge ref_clk);
      cmp_bit(ext_reset_pin_pullup, i != 0, "pull-up setting");
      drv_en <= 1'b1;
      repeat (12) @(posedge ref_clk);
      cmp_bit(core_reset, i != 0, "pin reset enable");
      if (i == 0) cmp_bit(gpio_in, 1'b0, "pin as input");
      drv_en <= 1'b0;
      wait_rst(1'b0, 12);
    end
    end_sim;
  end
endmodule : rsc_reset_cause_tb_top
`default_nettype wire
